/* File: verilog/dac_serial_pkg.sv */
// Shared constants, types and helpers of the converter serial control block.
package dac_serial_pkg;

	// ==========================================================================
	// Frame geometry and checksum
	// ==========================================================================
	localparam logic [5:0] FRAME_BITS_PLAIN   = 6'h18;
	localparam logic [5:0] FRAME_BITS_CHECKED = 6'h20;
	localparam logic [5:0] BIT_COUNT_MAX      = 6'h3F;
	// Generator x^8+x^2+x+1 without its leading term.
	localparam logic [7:0] CRC_POLY           = 8'h07;
	localparam logic [7:0] CRC_INIT           = 8'h00;

	// ==========================================================================
	// Device register addresses and reset values
	// ==========================================================================
	localparam logic [3:0]  ADDR_NOP     = 4'h0;
	localparam logic [3:0]  ADDR_ID      = 4'h1;
	localparam logic [3:0]  ADDR_SYNC    = 4'h2;
	localparam logic [3:0]  ADDR_CONFIG  = 4'h3;
	localparam logic [3:0]  ADDR_BRDCAST = 4'h6;
	localparam logic [3:0]  ADDR_DAC0    = 4'h8;
	localparam logic [15:0] RST_SYNC     = 16'hFF00;
	localparam logic [15:0] RST_ZERO     = 16'h0000;
	// Identity word returned at the identity address; the value is arbitrary.
	localparam logic [15:0] DEV_ID_DEFAULT = 16'h0A51;

	// ==========================================================================
	// Configuration field positions
	// ==========================================================================
	localparam int CFG_ALERT_SEL_BIT  = 13;
	localparam int CFG_ALERT_EN_BIT   = 12;
	localparam int CFG_CRC_EN_BIT     = 11;
	localparam int CFG_EDGE_SEL_BIT   = 10;
	localparam int CFG_REF_PD_BIT     = 8;
	localparam int CFG_DAC_PD_LSB     = 0;

	// ==========================================================================
	// Wishbone map (byte addresses)
	// ==========================================================================
	localparam logic [7:0] WB_ID_OFS     = 8'h00;
	localparam logic [7:0] WB_STATUS_OFS = 8'h04;
	localparam logic [7:0] WB_POWER_OFS  = 8'h08;
	localparam int         ST_CRC_ERR    = 0;
	localparam int         ST_SPACING    = 1;

	// ==========================================================================
	// Timing
	// ==========================================================================
	localparam int         CLK_PERIOD_NS      = 5;
	localparam int         UPDATE_SPACING_US  = 1;
	localparam logic [7:0] UPDATE_SPACING_CYC =
		8'((UPDATE_SPACING_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

	// ==========================================================================
	// Types
	// ==========================================================================
	typedef struct packed {
		logic       alert_source_select;
		logic       alert_output_enable;
		logic       crc_en;
		logic       readback_edge_select;
		logic       ref_pd;
		logic [3:0] dac_pd;
	} cfg_s;

	typedef enum {FS_IDLE, FS_CHECK, FS_SEAL} frame_state_e;

	function automatic cfg_s cfg_decode(input logic [15:0] w);
		cfg_s c;
		c.alert_source_select  = w[CFG_ALERT_SEL_BIT];
		c.alert_output_enable  = w[CFG_ALERT_EN_BIT];
		c.crc_en               = w[CFG_CRC_EN_BIT];
		c.readback_edge_select = w[CFG_EDGE_SEL_BIT];
		c.ref_pd               = w[CFG_REF_PD_BIT];
		c.dac_pd               = w[CFG_DAC_PD_LSB +: 4];
		return c;
	endfunction

	// Bit that the pin shows next: frame top, or the one below it.
	function automatic logic out_bit(input logic [31:0] s, input logic chk, input logic below);
		logic [4:0] idx;
		idx = chk ? 5'h1F : 5'h17;
		if (below)
			idx = idx - 5'h01;
		return s[idx];
	endfunction

endpackage

/* File: verilog/crc8_unit.sv */
// Combinational CRC-8 remainder of a 32-bit word, most significant bit first.
`timescale 1ns/100ps
module crc8_unit
	import dac_serial_pkg::*;
(
	// Data in
	input  wire logic [31:0] data_i,
	// Remainder out
	output logic      [7:0]  rem_o
);
	logic [7:0] r;
	logic       fb;

	always_comb begin
		r  = CRC_INIT;
		fb = 1'b0;
		for (int i = 31; i >= 0; i--) begin
			fb = r[7] ^ data_i[i];
			r  = {r[6:0], 1'b0} ^ (fb ? CRC_POLY : 8'h00);
		end
		rem_o = r;
	end
endmodule // crc8_unit

/* File: verilog/reg_store.sv */
// Sixteen-word register store with a registered read port.
`timescale 1ns/100ps
module reg_store
	import dac_serial_pkg::*;
(
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// Write port
	input  wire logic        wr_en_i,
	input  wire logic [3:0]  wr_addr_i,
	input  wire logic [15:0] wr_data_i,
	// Read port
	input  wire logic [3:0]  rd_addr_i,
	output logic      [15:0] rd_data_o
);
	logic [15:0] mem [16];

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			for (int i = 0; i < 16; i++)
				mem[i] <= (4'(i) == ADDR_SYNC) ? RST_SYNC : RST_ZERO;
		end else if (wr_en_i) begin
			mem[wr_addr_i] <= wr_data_i;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i)
			rd_data_o <= RST_ZERO;
		else
			rd_data_o <= mem[rd_addr_i];
	end
endmodule // reg_store

/* File: verilog/dac_serial_ctrl.sv */
// Serial frame engine, checked readback and alert pin of the quad converter.
// How it works
// - A read frame's answer leaves on the pin during the next frame.
// - Answer bit 31 echoes the read/write flag, one for reads.
// - Answer bit 30 is high if the prior frame failed its checksum.
// - Answer echoes the two reserved bits, then the four-bit address.
// - Answer bits 23:8 carry the addressed register's contents after an accepted read, else the frame's own data bits.
// - Answer ends with a CRC-8 over its upper twenty-four bits.
// - In alert mode the pin flags failed read frames like failed writes.
// - Each amplifier and the reference have separate power-down bits.
// - After reset every channel and the reference are powered up.
// - All registers read; no-op and identity ignore serial writes; chained devices pass writes through.
// - Checksum mode is switchable; off means plain 24-bit frames.
// - Checked frames are 32 bits, last byte a CRC-8, poly 0x107.
// - Checksum judged at chip-select rise; nonzero remainder drops frame.
// - Readback bits change on the edge chosen by the edge-select bit.
// - Pin is an alert only with alert enable 1 and source select 0.
`timescale 1ns/100ps
module dac_serial_ctrl
	import dac_serial_pkg::*;
(
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// Wishbone slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	// Serial port
	input  wire logic        sclk_i,
	input  wire logic        cs_n_i,
	input  wire logic        sdi_i,
	output logic             shared_out_alert_pin_o,
	output logic             shared_out_alert_pin_oe_n_o,
	// Power-down controls
	output logic      [3:0]  dac_pd_o,
	output logic             ref_pd_o
);
	// ==========================================================================
	// Edge detection
	// ==========================================================================
	logic sclk_prev, cs_prev;
	logic sclk_rise, sclk_fall, cs_rise, cs_fall;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sclk_prev <= 1'b0;
			cs_prev   <= 1'b1;
		end else begin
			sclk_prev <= sclk_i;
			cs_prev   <= cs_n_i;
		end
	end

	assign sclk_rise = sclk_i & ~sclk_prev;
	assign sclk_fall = ~sclk_i & sclk_prev;
	assign cs_rise   = cs_n_i & ~cs_prev;
	assign cs_fall   = ~cs_n_i & cs_prev;

	// ==========================================================================
	// Configuration and state
	// ==========================================================================
	logic [15:0]  cfg_word, dev_id, mem_rd, read_val, frame_data;
	cfg_s         cfg;
	frame_state_e state;
	logic [31:0]  shreg, frame;
	logic [5:0]   bit_cnt;
	logic [7:0]   rx_rem, tx_rem, spacing_cnt;
	logic [23:0]  resp24;
	logic [3:0]   frame_addr;
	logic [2:0]   frame_resv;
	logic         alarm_mode, frame_chk, len_ok, crc_err, rsp_read, accept;
	logic         mem_we, dac_upd, frame_rw, spacing_viol, wb_req;

	assign cfg = cfg_decode(cfg_word);
	assign alarm_mode = cfg.alert_output_enable & ~cfg.alert_source_select;

	assign frame_rw   = frame_chk ? frame[31] : frame[23];
	assign frame_resv = frame_chk ? {1'b0, frame[29:28]} : frame[22:20];
	assign frame_addr = frame_chk ? frame[27:24] : frame[19:16];
	assign frame_data = frame_chk ? frame[23:8] : frame[15:0];

	assign accept  = len_ok & (~frame_chk | (rx_rem == 8'h00));
	assign mem_we  = (state == FS_CHECK) & accept & ~frame_rw
		& (frame_addr != ADDR_NOP) & (frame_addr != ADDR_ID);
	assign dac_upd = mem_we & (frame_addr[3] | (frame_addr == ADDR_BRDCAST));

	crc8_unit rx_crc (
		.data_i (frame),
		.rem_o  (rx_rem)
	);

	reg_store store (
		.clk_i     (clk_i),
		.rst_i     (rst_i),
		.wr_en_i   (mem_we),
		.wr_addr_i (frame_addr),
		.wr_data_i (frame_data),
		.rd_addr_i (frame_addr),
		.rd_data_o (mem_rd)
	);

	// ==========================================================================
	// Frame sequencing
	// ==========================================================================
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state <= FS_IDLE;
		end else begin
			case (state)
				FS_IDLE:  state <= cs_rise ? FS_CHECK : FS_IDLE;
				FS_CHECK: state <= FS_SEAL;
				FS_SEAL:  state <= FS_IDLE;
				default:  state <= FS_IDLE;
			endcase
		end
	end

	// A chain of devices clocks more than one frame through; only the last
	// frame's worth of bits, the last ones shifted in from the data input, is kept.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			frame     <= 32'h0000_0000;
			frame_chk <= 1'b0;
			len_ok    <= 1'b0;
		end else if (state == FS_IDLE && cs_rise) begin
			frame     <= shreg;
			frame_chk <= cfg.crc_en;
			len_ok    <= bit_cnt >= (cfg.crc_en ? FRAME_BITS_CHECKED : FRAME_BITS_PLAIN);
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i)
			bit_cnt <= 6'h00;
		else if (cs_fall)
			bit_cnt <= 6'h00;
		else if (!cs_n_i && sclk_fall && bit_cnt != BIT_COUNT_MAX)
			bit_cnt <= bit_cnt + 6'h01;
	end

	// flag tracks the last full-length frame; plain frames clear it
	always_ff @(posedge clk_i) begin
		if (rst_i)
			crc_err <= 1'b0;
		else if (state == FS_CHECK && len_ok)
			crc_err <= frame_chk & (rx_rem != 8'h00);
	end

	always_ff @(posedge clk_i) begin
		if (rst_i)
			rsp_read <= 1'b0;
		else if (state == FS_CHECK)
			rsp_read <= accept & frame_rw;
	end

	// power bits live in the config word
	always_ff @(posedge clk_i) begin
		if (rst_i)
			cfg_word <= RST_ZERO;
		else if (mem_we && frame_addr == ADDR_CONFIG)
			cfg_word <= frame_data;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dac_pd_o <= 4'h0;
			ref_pd_o <= 1'b0;
		end else begin
			dac_pd_o <= cfg.dac_pd;
			ref_pd_o <= cfg.ref_pd;
		end
	end

	// ==========================================================================
	// Answer assembly
	// ==========================================================================
	// every register reads back
	assign read_val = (frame_addr == ADDR_ID) ? dev_id
		: (frame_addr == ADDR_CONFIG) ? cfg_word : mem_rd;

	always_comb begin
		if (cfg.crc_en)
			resp24 = {frame_rw, crc_err, frame_resv[1:0], frame_addr,
				rsp_read ? read_val : frame_data};
		else
			resp24 = {frame_rw, frame_resv, frame_addr, rsp_read ? read_val : frame_data};
	end

	crc8_unit tx_crc (
		.data_i ({8'h00, resp24}),
		.rem_o  (tx_rem)
	);

	// answer loaded for the next frame
	always_ff @(posedge clk_i) begin
		if (rst_i)
			shreg <= 32'h0000_0000;
		else if (state == FS_SEAL)
			shreg <= cfg.crc_en ? {resp24, tx_rem} : {8'h00, resp24};
		else if (!cs_n_i && sclk_fall)
			shreg <= {shreg[30:0], sdi_i};
	end

	// ==========================================================================
	// Shared output pin
	// ==========================================================================
	// alert shows failed frames
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			shared_out_alert_pin_o      <= 1'b0;
			shared_out_alert_pin_oe_n_o <= 1'b1;
		end else if (alarm_mode) begin
			shared_out_alert_pin_o      <= crc_err;
			shared_out_alert_pin_oe_n_o <= 1'b0;
		end else if (cs_fall) begin
			shared_out_alert_pin_o      <= out_bit(shreg, cfg.crc_en, 1'b0);
			shared_out_alert_pin_oe_n_o <= 1'b0;
		end else if (cs_n_i) begin
			shared_out_alert_pin_oe_n_o <= 1'b1;
		end else if (sclk_fall && cfg.readback_edge_select) begin
			shared_out_alert_pin_o      <= out_bit(shreg, cfg.crc_en, 1'b1);
		end else if (sclk_rise && !cfg.readback_edge_select) begin
			shared_out_alert_pin_o      <= out_bit(shreg, cfg.crc_en, 1'b0);
		end
	end

	// ==========================================================================
	// Update spacing watch
	// ==========================================================================
	// flag updates closer than 1 us
	always_ff @(posedge clk_i) begin
		if (rst_i)
			spacing_cnt <= UPDATE_SPACING_CYC;
		else if (dac_upd)
			spacing_cnt <= 8'h00;
		else if (spacing_cnt != UPDATE_SPACING_CYC)
			spacing_cnt <= spacing_cnt + 8'h01;
	end

	// Setting wins over a software clear in the same cycle.
	always_ff @(posedge clk_i) begin
		if (rst_i)
			spacing_viol <= 1'b0;
		else if (dac_upd && spacing_cnt < UPDATE_SPACING_CYC)
			spacing_viol <= 1'b1;
		else if (wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i
			&& wb_adr_i == WB_STATUS_OFS && wb_sel_i[0] && wb_dat_i[ST_SPACING])
			spacing_viol <= 1'b0;
	end

	// ==========================================================================
	// Wishbone slave
	// ==========================================================================
	assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;

	always_ff @(posedge clk_i) begin
		if (rst_i)
			wb_ack_o <= 1'b0;
		else
			wb_ack_o <= wb_req;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dev_id <= DEV_ID_DEFAULT;
		end else if (wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_adr_i == WB_ID_OFS) begin
			if (wb_sel_i[0])
				dev_id[7:0] <= wb_dat_i[7:0];
			if (wb_sel_i[1])
				dev_id[15:8] <= wb_dat_i[15:8];
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_dat_o <= 32'h0000_0000;
		end else if (wb_req) begin
			case (wb_adr_i)
				WB_ID_OFS:     wb_dat_o <= {16'h0000, dev_id};
				WB_STATUS_OFS: wb_dat_o <= {28'h000_0000, alarm_mode, cfg.crc_en,
					spacing_viol, crc_err};
				WB_POWER_OFS:  wb_dat_o <= {27'h000_0000, cfg.ref_pd, cfg.dac_pd};
				default:       wb_dat_o <= 32'h0000_0000;
			endcase
		end
	end

	// ==========================================================================
	// Checks
	// ==========================================================================
	a_ack_single_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
		wb_ack_o |=> !wb_ack_o) else $error("ack held longer than one cycle");
	a_frame_seq_order: assert property (@(posedge clk_i) disable iff (rst_i)
		state == FS_CHECK |=> state == FS_SEAL ##1 state == FS_IDLE)
		else $error("frame sequencer skipped a step");
	a_crc_flag_set: assert property (@(posedge clk_i) disable iff (rst_i)
		(state == FS_CHECK && len_ok && frame_chk && rx_rem != 8'h00) |=> crc_err)
		else $error("fault flag not raised for bad checksum");
	a_bad_frame_dropped: assert property (@(posedge clk_i) disable iff (rst_i)
		(state == FS_CHECK && frame_chk && rx_rem != 8'h00) |-> !mem_we)
		else $error("frame with bad checksum was written");
	a_resp_top_bits: assert property (@(posedge clk_i) disable iff (rst_i)
		(state == FS_SEAL && cfg.crc_en)
		|=> shreg[31:30] == {$past(frame_rw), $past(crc_err)})
		else $error("answer flag bits wrong");
	a_resp_crc_seal: assert property (@(posedge clk_i) disable iff (rst_i)
		(state == FS_SEAL && cfg.crc_en) |=> shreg[7:0] == $past(tx_rem)
		&& shreg[31:8] == $past(resp24)) else $error("answer checksum wrong");
	a_alert_follows: assert property (@(posedge clk_i) disable iff (rst_i)
		alarm_mode |=> !shared_out_alert_pin_oe_n_o
		&& shared_out_alert_pin_o == $past(crc_err))
		else $error("alert pin does not follow fault flag");
	a_power_at_reset: assert property (@(posedge clk_i) disable iff (rst_i)
		$fell(rst_i) |-> dac_pd_o == 4'h0 && !ref_pd_o)
		else $error("power-down active after reset");
	a_edge_sel_fall: assert property (@(posedge clk_i) disable iff (rst_i)
		(!alarm_mode && !cs_n_i && !cs_prev && sclk_fall && cfg.readback_edge_select)
		|=> shared_out_alert_pin_o == $past(out_bit(shreg, cfg.crc_en, 1'b1)))
		else $error("readback bit not updated on falling edge");
	a_spacing_flag: assert property (@(posedge clk_i) disable iff (rst_i)
		(dac_upd && spacing_cnt < UPDATE_SPACING_CYC) |=> spacing_viol)
		else $error("close updates not flagged");
endmodule // dac_serial_ctrl

/* File: sim/spi_host_model.sv */
// Behavioural serial host that shifts frames into the converter control block.
`timescale 1ns/100ps
module spi_host_model (
	// Clock
	input  wire logic clk_i,
	// Serial lines
	input  wire logic pin_i,
	output logic      sclk_o,
	output logic      cs_n_o,
	output logic      sdi_o
);
	logic in_frame;

	initial begin
		sclk_o = 1'b0;
		cs_n_o = 1'b1;
		sdi_o = 1'b0;
		in_frame = 1'b0;
	end

	// A released data line toggles, so that a stale bit can never pass for data.
	always @(posedge clk_i) begin
		if (!in_frame)
			sdi_o <= ~sdi_o;
	end

	// ==========================================================================
	// Frame transfer
	// ==========================================================================
	// whole frames shifted
	task automatic xfer(input logic [31:0] tx, input int n, input logic sel,
		output logic [31:0] rx);
		int i;
		rx = '0;
		@(posedge clk_i);
		in_frame <= 1'b1;
		cs_n_o <= 1'b0;
		for (i = n - 1; i >= 0; i--) begin
			@(posedge clk_i);
			sdi_o <= tx[i];
			repeat (3) @(posedge clk_i);
			// Sample in the half period after the edge on which the block moves the pin.
			if (sel)
				rx[i] = pin_i;
			sclk_o <= 1'b1;
			repeat (4) @(posedge clk_i);
			if (!sel)
				rx[i] = pin_i;
			sclk_o <= 1'b0;
		end
		repeat (4) @(posedge clk_i);
		cs_n_o <= 1'b1;
		in_frame <= 1'b0;
		repeat (6) @(posedge clk_i);
	endtask
endmodule // spi_host_model

/* File: sim/tb.sv */
// Self-checking bench of the converter serial control block.
`timescale 1ns/100ps
module tb
	import dac_serial_pkg::*;
;
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
	logic [7:0]  wb_adr_i = 8'h00;
	logic [3:0]  wb_sel_i = 4'h0;
	logic [31:0] wb_dat_i = 32'h0000_0000, wb_dat_o, q, rx;
	logic        wb_ack_o, sclk, cs_n, sdi, pin, pin_oe_n, ref_pd;
	logic [3:0]  dac_pd;
	logic        chk = 1'b0, sel = 1'b0;
	logic [15:0] d, cfg;
	int          n_fail = 0, checks_done = 0, seed, k, e;

	always #2.5 clk_i = ~clk_i;

	dac_serial_ctrl u_dut (
		.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .sclk_i(sclk), .cs_n_i(cs_n),
		.sdi_i(sdi), .shared_out_alert_pin_o(pin), .shared_out_alert_pin_oe_n_o(pin_oe_n),
		.dac_pd_o(dac_pd), .ref_pd_o(ref_pd)
	);
	spi_host_model u_host (
		.clk_i(clk_i), .pin_i(pin_oe_n ? ~pin : pin), .sclk_o(sclk), .cs_n_o(cs_n), .sdi_o(sdi)
	);

	// ==========================================================================
	// Expectations
	// ==========================================================================
	function automatic logic [7:0] crc8(input logic [23:0] h);
		logic [7:0] c;
		c = 8'h00;
		for (int i = 23; i >= 0; i--)
			c = {c[6:0], 1'b0} ^ ((c[7] ^ h[i]) ? 8'h07 : 8'h00);
		return c;
	endfunction

	function automatic logic [31:0] mk(input logic rw, fl, input logic [3:0] a,
		input logic [15:0] dv);
		logic [23:0] h;
		h = {rw, fl, 2'b00, a, dv};
		return chk ? {h, crc8(h)} : {8'h00, h};
	endfunction

	// ==========================================================================
	// Bus, serial and report tasks
	// ==========================================================================
	task automatic check(input string nm, input logic [31:0] seen, exp);
		checks_done++;
		if (seen !== exp) begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic results();
		$display("checks %0d failures %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] v);
		int t;
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_dat_i <= v;
		wb_sel_i <= 4'hF;
		t = 0;
		do begin
			@(posedge clk_i);
			t++;
		end while (wb_ack_o !== 1'b1 && t < 40);
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		if (wb_ack_o !== 1'b1) begin
			n_fail++;
			results();
		end
	endtask

	task automatic send(input logic [31:0] f);
		u_host.xfer(f, chk ? 32 : 24, sel, rx);
	endtask

	// A read is answered only during the following frame.
	task automatic rd(input string nm, input logic [3:0] a, input logic [15:0] v);
		send(mk(1'b1, 1'b0, a, 16'h0000));
		send(mk(1'b0, 1'b0, ADDR_NOP, 16'h0000));
		check(nm, rx, mk(1'b1, 1'b0, a, v));
	endtask

	task automatic cfgw(input logic [15:0] v);
		send(mk(1'b0, 1'b0, ADDR_CONFIG, v));
		chk = v[CFG_CRC_EN_BIT];
		sel = v[CFG_EDGE_SEL_BIT];
	endtask

	// ==========================================================================
	// Main sequence
	// ==========================================================================
	initial begin
		seed = $urandom(32'h68ba);
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		check("pd_reset", 32'({ref_pd, dac_pd}), 32'h0);
		check("oe_reset", 32'(pin_oe_n), 32'h1);
		wb(1'b0, WB_POWER_OFS, 32'h0);
		check("power_reset", q, 32'h0);
		wb(1'b0, 8'hFC, 32'h0);
		check("unmapped", q, 32'h0);
		d = 16'($urandom);
		wb(1'b1, WB_ID_OFS, {16'h0000, d});
		rd("id", ADDR_ID, d);
		d = 16'($urandom);
		send(mk(1'b0, 1'b0, ADDR_DAC0, d));
		rd("plain", ADDR_DAC0, d);
		for (e = 0; e < 2; e++) begin
			for (k = 0; k < 4; k++) begin
				cfg = 16'($urandom) & 16'h010F;
				cfg[CFG_CRC_EN_BIT] = 1'b1;
				cfg[CFG_EDGE_SEL_BIT] = e[0];
				cfgw(cfg);
				check("pd", 32'({ref_pd, dac_pd}), 32'({cfg[8], cfg[3:0]}));
				wb(1'b0, WB_POWER_OFS, 32'h0);
				check("power", q, 32'({cfg[8], cfg[3:0]}));
				rd("cfg", ADDR_CONFIG, cfg);
				d = 16'($urandom);
				// each frame outlasts the update spacing
				send(mk(1'b0, 1'b0, ADDR_DAC0 + 4'(k), d));
				rd("dac", ADDR_DAC0 + 4'(k), d);
			end
		end
		send(mk(1'b0, 1'b0, ADDR_DAC0 + 4'h3, ~d) ^ 32'h0000_0001);
		send(mk(1'b1, 1'b0, ADDR_DAC0 + 4'h3, 16'h0000));
		check("wr_fault", 32'(rx[30]), 32'h1);
		send(mk(1'b0, 1'b0, ADDR_NOP, 16'h0000));
		check("kept", rx, mk(1'b1, 1'b0, ADDR_DAC0 + 4'h3, d));
		send(mk(1'b1, 1'b0, ADDR_DAC0, 16'h0000) ^ 32'h0000_0080);
		wb(1'b0, WB_STATUS_OFS, 32'h0);
		check("status_fault", 32'(q[0]), 32'h1);
		check("spacing_ok", 32'(q[1]), 32'h0);
		send(mk(1'b0, 1'b0, ADDR_NOP, 16'h0000));
		check("rd_fault", 32'(rx[31:30]), 32'h3);
		cfg[CFG_ALERT_EN_BIT] = 1'b1;
		cfgw(cfg);
		send(mk(1'b1, 1'b0, ADDR_DAC0, 16'h0000) ^ 32'h0000_0100);
		check("alert", 32'({pin_oe_n, pin}), 32'h1);
		wb(1'b0, WB_STATUS_OFS, 32'h0);
		check("status_mode", 32'({q[3:2], q[0]}), 32'h7);
		send(mk(1'b0, 1'b0, ADDR_NOP, 16'h0000));
		check("alert_clear", 32'({pin_oe_n, pin}), 32'h0);
		cfg[CFG_ALERT_SEL_BIT] = 1'b1;
		cfgw(cfg);
		check("alert_off", 32'(pin_oe_n), 32'h1);
		cfgw(16'h0000);
		d = 16'($urandom);
		send(mk(1'b0, 1'b0, ADDR_DAC0 + 4'h1, d));
		rd("plain_again", ADDR_DAC0 + 4'h1, d);
		results();
	end

	initial begin
		repeat (100000) @(posedge clk_i);
		n_fail++;
		results();
	end
endmodule // tb
